// >>> design/fskrx_pkg.sv
// Purpose: Constants for the FSK receiver three-wire word output block
// Assumes: System clock of 100 MHz; demodulator timebase of 3.579545 MHz
// Notes: Long counts are derived here and overridable at the top level
package fskrx_pkg;

	// ****************************************
	// Clock figures
	// ****************************************
	localparam longint FSKRX_SYS_CLK_HZ = 64'd100000000;
	localparam longint FSKRX_MASTER_CLK_HZ = 64'd3579545;
	// Bit clock burst rate is the master clock divided by this
	localparam longint FSKRX_BIT_DIV = 64'd2976;
	// One bit cell in system clocks, rounded down
	localparam int FSKRX_BIT_CYCLES =
		int'(FSKRX_SYS_CLK_HZ * FSKRX_BIT_DIV / FSKRX_MASTER_CLK_HZ);

	// ****************************************
	// Carrier detect hysteresis
	// ****************************************
	localparam longint FSKRX_CD_ON_TIME_US = 64'd10;
	localparam longint FSKRX_CD_OFF_TIME_US = 64'd8;
	localparam int FSKRX_CD_ON_CYCLES =
		int'(FSKRX_CD_ON_TIME_US * FSKRX_SYS_CLK_HZ / 64'd1000000);
	localparam int FSKRX_CD_OFF_CYCLES =
		int'(FSKRX_CD_OFF_TIME_US * FSKRX_SYS_CLK_HZ / 64'd1000000);

	// ****************************************
	// Widths and word layout
	// ****************************************
	localparam int FSKRX_CNT_W = 20;
	localparam logic [3:0] FSKRX_DATA_BITS = 4'h8;

	typedef enum logic [2:0] {
		FSKRX_IDLE,
		FSKRX_LEAD,
		FSKRX_BURST,
		FSKRX_READY,
		FSKRX_STOP
	} fskrx_state_t;

endpackage

// >>> design/fskrx_word_out.sv
// Purpose: Frame the demodulated FSK bit stream into a data/bit-clock/ready interface
// Assumes: Demodulator and energy detector outputs are asynchronous levels
// Notes: Open-drain pins drive low when their enable (active low) is low
//
// Behaviour
// [R1] Power-down stops all operation
// [R2] Stop-start sequence triggers eight bit clock pulses
// [R3] Bit clock rises at data cell centre
// [R4] No bit clock during start or stop
// [R5] One ready pulse per ten-bit word
// [R6] Power-down: data, clock high; open-drains released
// [R7] Powered down: line input ignored entirely
// [R8] Host drives power-down low to receive
// [R9] Carrier output low while FSK detected
// [R10] Carrier indication has time hysteresis
// [R11] Voice may activate outputs; not filtered
// [R12] Host ignores outputs when no data expected
// [R13] Timing derived from one master timebase
// [R14] Bit clock rate master/2976, low pulses
// [R15] Data high until carrier present; mark high
// [R16] Ready goes low after last pulse
// [R17] Ready released before next word's pulses
`timescale 1ns/1ps
module fskrx_word_out
	import fskrx_pkg::*;
#(
	parameter int BIT_CYCLES = FSKRX_BIT_CYCLES,
	parameter int CD_ON_CYCLES = FSKRX_CD_ON_CYCLES,
	parameter int CD_OFF_CYCLES = FSKRX_CD_OFF_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Controls and front-end levels (asynchronous)
	input wire logic power_down_in,
	input wire logic demod_bit_in,
	input wire logic carrier_energy_in,
	// Three-wire interface
	output logic serial_data_out,
	output logic bit_clock_out,
	// Open-drain word ready
	output logic word_ready_n_out,
	output logic word_ready_n_oe_n,
	// Open-drain carrier present
	output logic carrier_present_n_out,
	output logic carrier_present_n_oe_n
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;

	// Two flops per asynchronous input, first stage read only by second
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync1_reg <= 3'h1;
			sync2_reg <= 3'h1;
		end
		else
		begin
			sync1_reg <= {carrier_energy_in, demod_bit_in, power_down_in};
			sync2_reg <= sync1_reg;
		end
	end

	wire pd = sync2_reg[0];
	// Front end is off while powered down, so its levels are masked [R7]
	wire line_bit = pd ? 1'b1 : sync2_reg[1];
	wire energy = pd ? 1'b0 : sync2_reg[2];

	// ****************************************
	// Carrier detect with hysteresis
	// ****************************************
	logic carrier_reg;
	logic carrier_next;
	logic [FSKRX_CNT_W-1:0] cd_cnt_reg;
	logic [FSKRX_CNT_W-1:0] cd_cnt_next;

	// Energy is counted towards the opposite state; the count restarts on agreement.
	// Voice in band counts just the same, nothing distinguishes it [R11]
	wire cd_disagree = energy != carrier_reg;
	wire [FSKRX_CNT_W-1:0] cd_limit = carrier_reg ?
		FSKRX_CNT_W'(CD_OFF_CYCLES - 1) : FSKRX_CNT_W'(CD_ON_CYCLES - 1);
	wire cd_flip = cd_disagree && (cd_cnt_reg >= cd_limit); // [R10]
	assign cd_cnt_next = (!cd_disagree || cd_flip) ? '0 : cd_cnt_reg + 1'b1;
	assign carrier_next = pd ? 1'b0 : (cd_flip ? energy : carrier_reg); // [R9]

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			carrier_reg <= 1'b0;
			cd_cnt_reg <= '0;
		end
		else
		begin
			carrier_reg <= carrier_next;
			cd_cnt_reg <= cd_cnt_next;
		end
	end

	// ****************************************
	// Word framing and bit clock burst
	// ****************************************
	fskrx_state_t state_reg;
	fskrx_state_t state_next;
	logic [FSKRX_CNT_W-1:0] tick_reg;
	logic [FSKRX_CNT_W-1:0] tick_next;
	logic [3:0] pulse_reg;
	logic [3:0] pulse_next;
	logic prev_bit_reg;

	// Data follows the line only once carrier is up [R15]
	wire data_bit = carrier_reg ? line_bit : 1'b1;
	// Falling edge after a high (stop or mark) level opens a word [R2]
	wire start_edge = prev_bit_reg && !data_bit;
	wire [FSKRX_CNT_W-1:0] bit_last = FSKRX_CNT_W'(BIT_CYCLES - 1); // [R13]
	wire [FSKRX_CNT_W-1:0] half_last = FSKRX_CNT_W'(BIT_CYCLES / 2 - 1);
	wire tick_bit_end = tick_reg == bit_last;
	wire tick_half_end = tick_reg == half_last;
	// Low half of each pulse ends at a cell centre, so the rise lands there [R3] [R14]
	wire burst_low = (state_reg == FSKRX_BURST) && (tick_reg <= half_last);

	always_comb
	begin
		state_next = state_reg;
		tick_next = tick_reg + 1'b1;
		pulse_next = pulse_reg;
		unique case (state_reg)
			FSKRX_IDLE:
			begin
				tick_next = '0;
				if (start_edge)
					state_next = FSKRX_LEAD;
			end
			FSKRX_LEAD:
			begin
				// Whole start cell passes with no pulse [R4]
				if (tick_bit_end)
				begin
					tick_next = '0;
					pulse_next = '0;
					state_next = FSKRX_BURST;
				end
			end
			FSKRX_BURST:
			begin
				if (tick_bit_end)
				begin
					tick_next = '0;
					pulse_next = pulse_reg + 1'b1;
					if (pulse_reg == FSKRX_DATA_BITS - 4'h1) // [R2]
						state_next = FSKRX_READY;
				end
			end
			FSKRX_READY:
			begin
				// Ready low for half the stop cell, released well before next start [R17]
				if (tick_half_end)
				begin
					tick_next = '0;
					state_next = FSKRX_STOP;
				end
			end
			FSKRX_STOP:
			begin
				// One cycle only, no pulse; idle then watches for a new start through the rest of the stop cell [R4]
				tick_next = '0;
				state_next = FSKRX_IDLE;
			end
		endcase
		if (pd)
		begin
			state_next = FSKRX_IDLE; // [R1]
			tick_next = '0;
			pulse_next = '0;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= FSKRX_IDLE;
			tick_reg <= '0;
			pulse_reg <= '0;
			prev_bit_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			tick_reg <= tick_next;
			pulse_reg <= pulse_next;
			prev_bit_reg <= data_bit;
		end
	end

	// ****************************************
	// Output flops
	// ****************************************
	logic data_out_reg;
	logic bclk_reg;
	logic ready_oe_n_reg;
	logic cd_oe_n_reg;
	logic drain_level_reg;

	// Power-down forces data and clock high, open drains released [R6]
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			data_out_reg <= 1'b1;
			bclk_reg <= 1'b1;
			ready_oe_n_reg <= 1'b1;
			cd_oe_n_reg <= 1'b1;
			drain_level_reg <= 1'b0;
		end
		else
		begin
			data_out_reg <= pd ? 1'b1 : data_bit; // [R15]
			bclk_reg <= pd ? 1'b1 : !burst_low; // [R14]
			ready_oe_n_reg <= pd ? 1'b1 : (state_next != FSKRX_READY); // [R5] [R16]
			cd_oe_n_reg <= pd ? 1'b1 : !carrier_next; // [R9]
			drain_level_reg <= 1'b0; // Open drain only ever pulls low
		end
	end

	assign serial_data_out = data_out_reg;
	assign bit_clock_out = bclk_reg;
	assign word_ready_n_out = drain_level_reg;
	assign word_ready_n_oe_n = ready_oe_n_reg;
	assign carrier_present_n_out = drain_level_reg;
	assign carrier_present_n_oe_n = cd_oe_n_reg;

endmodule // fskrx_word_out

// >>> bench/fskrx_word_out_chk.sv
// Purpose: Port checks for the FSK word output block
// Assumes: One clock, async active-low reset
// Notes: Counters measure pulse widths and pulses per word
`timescale 1ns/1ps
module fskrx_word_out_chk
	import fskrx_pkg::*;
#(parameter int BIT_CYCLES = FSKRX_BIT_CYCLES)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Inputs
	input wire logic power_down_in,
	input wire logic carrier_energy_in,
	// Outputs
	input wire logic serial_data_out,
	input wire logic bit_clock_out,
	input wire logic word_ready_n_oe_n,
	input wire logic carrier_present_n_oe_n
);
	int lo_cnt;
	int rd_cnt;
	logic [3:0] pc;
	// Counters, since long repetitions choke the tools
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lo_cnt <= 0;
			rd_cnt <= 0;
			pc <= 4'h0;
		end
		else
		begin
			lo_cnt <= bit_clock_out ? 0 : lo_cnt + 1;
			rd_cnt <= word_ready_n_oe_n ? 0 : rd_cnt + 1;
			pc <= (power_down_in || $fell(word_ready_n_oe_n)) ? 4'h0 : pc + 4'($fell(bit_clock_out));
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	pd_idle_a: assert property (power_down_in[*4] |-> serial_data_out && bit_clock_out)
		else $error("outputs not high in power down");
	pd_release_a: assert property (power_down_in[*4] |-> word_ready_n_oe_n && carrier_present_n_oe_n)
		else $error("open drain driven in power down");
	nocd_data_a: assert property (carrier_present_n_oe_n && $past(carrier_present_n_oe_n) |-> serial_data_out)
		else $error("data low without carrier");
	bclk_width_a: assert property ($rose(bit_clock_out) |-> lo_cnt == BIT_CYCLES / 2)
		else $error("bit clock low width wrong");
	burst_count_a: assert property ($fell(word_ready_n_oe_n) |-> pc == 4'h8)
		else $error("burst not eight pulses");
	rdy_width_a: assert property ($rose(word_ready_n_oe_n) |-> rd_cnt == BIT_CYCLES / 2)
		else $error("ready width wrong");
	rdy_after_a: assert property ($fell(word_ready_n_oe_n) |-> $past(bit_clock_out, 9) && bit_clock_out)
		else $error("ready not after last pulse");
	rdy_quiet_a: assert property (!word_ready_n_oe_n |-> bit_clock_out)
		else $error("bit clock during ready");
	cd_on_a: assert property ($fell(carrier_present_n_oe_n) |-> $past(carrier_energy_in, 4))
		else $error("carrier without energy");
	cover property ($fell(word_ready_n_oe_n));
	cover property ($fell(carrier_present_n_oe_n));
	cover property ($rose(carrier_present_n_oe_n));
endmodule // fskrx_word_out_chk
bind fskrx_word_out fskrx_word_out_chk #(.BIT_CYCLES(BIT_CYCLES)) chk_u (.clk(clk),
	.reset_n(reset_n), .power_down_in(power_down_in), .carrier_energy_in(carrier_energy_in),
	.serial_data_out(serial_data_out), .bit_clock_out(bit_clock_out),
	.word_ready_n_oe_n(word_ready_n_oe_n), .carrier_present_n_oe_n(carrier_present_n_oe_n));

// >>> bench/fskrx_host_model.sv
// Purpose: Host shift register and latch on the three-wire pins
// Assumes: Pins already resolved to levels
// Notes: Counts clock pulses per latched word
`timescale 1ns/1ps
module fskrx_host_model
(
	// Pins
	input wire logic sdata,
	input wire logic bclk,
	input wire logic rdy_n,
	// Results
	output logic [7:0] word,
	output logic [7:0] bits,
	output int n_words
);
	logic [7:0] sr = 8'h00;
	logic [7:0] falls = 8'h00;
	logic [7:0] base = 8'h00;
	initial n_words = 0;
	// Shift on rising clock, first bit ends up lowest
	always @(posedge bclk)
		sr <= {sdata, sr[7:1]};
	// Pulses counted on their fall, so the rise out of power-up unknown is no pulse
	always @(negedge bclk)
		falls <= falls + 8'h01;
	// Only ready-framed bits are taken; count is per word, one driver each
	always @(negedge rdy_n)
	begin
		word <= sr;
		bits <= falls - base;
		base <= falls;
		n_words <= n_words + 1;
	end
endmodule // fskrx_host_model

// >>> bench/test_fsk_rx_serial_word_output.sv
// Purpose: Self-checking bench for the FSK word output block
// Assumes: Short sim counts, line baud equals burst rate
// Notes: Words are sent back to back with one stop bit
`timescale 1ns/1ps
module test_fsk_rx_serial_word_output
	import fskrx_pkg::*;
;
	localparam int T = 20;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic power_down_in = 1'b0;
	logic demod_bit_in = 1'b1;
	logic carrier_energy_in = 1'b0;
	logic sdo, bco, rdo, rdoe, cdo, cdoe;
	logic [7:0] word, bits;
	int n_words;
	int err_total = 0;
	int n_checks = 0;
	logic [15:0] rows [4] = '{16'h0000, 16'hffff, 16'ha5a5, 16'h3c3c};
	// Pull-ups on the open drains
	wire rdy_pin = rdoe ? 1'b1 : rdo;
	wire cd_pin = cdoe ? 1'b1 : cdo;
	always #5 clk = ~clk;
	fskrx_word_out #(.BIT_CYCLES(T), .CD_ON_CYCLES(8), .CD_OFF_CYCLES(6)) dut_u (.clk(clk),
		.reset_n(reset_n), .power_down_in(power_down_in), .demod_bit_in(demod_bit_in),
		.carrier_energy_in(carrier_energy_in), .serial_data_out(sdo), .bit_clock_out(bco),
		.word_ready_n_out(rdo), .word_ready_n_oe_n(rdoe), .carrier_present_n_out(cdo),
		.carrier_present_n_oe_n(cdoe));
	fskrx_host_model host_u (.sdata(sdo), .bclk(bco), .rdy_n(rdy_pin), .word(word),
		.bits(bits), .n_words(n_words));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One frame: start, eight data bits low first, stop
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			demod_bit_in <= f[i];
			cyc(T);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		cyc(2);
		reset_n <= 1'b1;
		cyc(3);
		chk({sdo, bco, rdy_pin, cd_pin, 4'h0}, 8'hf0);
		carrier_energy_in <= 1'b1;
		cyc(20);
		chk({7'h00, cd_pin}, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			send(rows[i][15:8]);
			chk(word, rows[i][7:0]);
			chk(bits, 8'h08);
			chk(8'(n_words), 8'(i + 1));
		end
		$display("words done");
		carrier_energy_in <= 1'b0;
		cyc(3);
		carrier_energy_in <= 1'b1;
		cyc(10);
		chk({7'h00, cd_pin}, 8'h00);
		carrier_energy_in <= 1'b0;
		cyc(20);
		chk({7'h00, cd_pin}, 8'h01);
		send(8'h5a);
		chk(8'(n_words), 8'h04);
		$display("carrier done");
		carrier_energy_in <= 1'b1;
		power_down_in <= 1'b1;
		cyc(20);
		chk({sdo, bco, rdy_pin, cd_pin, 4'h0}, 8'hf0);
		send(8'h81);
		chk(8'(n_words), 8'h04);
		power_down_in <= 1'b0;
		cyc(20);
		send(8'h81);
		chk(word, 8'h81);
		$display("power down done");
		// Reset in mid-run: outputs idle, carrier must be found again
		reset_n <= 1'b0;
		cyc(2);
		reset_n <= 1'b1;
		cyc(3);
		chk({sdo, bco, rdy_pin, cd_pin, 4'h0}, 8'hf0);
		cyc(20);
		chk({7'h00, cd_pin}, 8'h00);
		$display("reset done");
		print_verdict();
	end
endmodule // test_fsk_rx_serial_word_output
